// ===== logic/brtc_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * real time clock register window.
 * Assumes a 17-bit byte address from the host memory port.
 */
`ifndef BRTC_MAP_SVH
`define BRTC_MAP_SVH

`define BRTC_ADDR_FLAGS     17'h1fff0
`define BRTC_ADDR_AL_SEC    17'h1fff2
`define BRTC_ADDR_AL_MIN    17'h1fff3
`define BRTC_ADDR_AL_HOUR   17'h1fff4
`define BRTC_ADDR_AL_DATE   17'h1fff5
`define BRTC_ADDR_INTR      17'h1fff6
`define BRTC_ADDR_CAL       17'h1fff8
`define BRTC_ADDR_SEC       17'h1fff9
`define BRTC_ADDR_MIN       17'h1fffa
`define BRTC_ADDR_HOUR      17'h1fffb
`define BRTC_ADDR_WDAY      17'h1fffc
`define BRTC_ADDR_DATE      17'h1fffd
`define BRTC_ADDR_MONTH     17'h1fffe
`define BRTC_ADDR_YEAR      17'h1ffff

// Flags register fields.
`define BRTC_FL_READ        0
`define BRTC_FL_WRITE       1
`define BRTC_FL_OSC_FAIL_FLAG        2
`define BRTC_FL_CAL         3
`define BRTC_FL_AF          6
// Calibration register fields.
`define BRTC_CAL_SIGN       5
`define BRTC_CAL_OSCDIS     7
`define BRTC_CAL_RESET      8'h00
// Interrupt register field.
`define BRTC_INT_AIE        6

// Oscillator timing, in oscillator ticks (32768 Hz).
`define BRTC_TICKS_PER_SEC  15'd32767
`define BRTC_CAL_SHORT      9'd128
`define BRTC_CAL_LONG       9'd256
`define BRTC_TEST_HALF      6'd31
// Host clock timing.
`define BRTC_CLK_NS         10
`define BRTC_OSC_FAIL_MS    5
`define BRTC_OSC_FAIL_CYC   ((`BRTC_OSC_FAIL_MS * 1000000) / `BRTC_CLK_NS)
`define BRTC_REFRESH_MS     20
`define BRTC_REFRESH_CYC    ((`BRTC_REFRESH_MS * 1000000) / `BRTC_CLK_NS)

`endif

// ===== logic/brtc_pkg.sv
/*
 * Types shared by the real time clock core.
 * Assumes brtc_map.svh supplies all numeric constants.
 */
package brtc_pkg;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } brtc_time_t;

   typedef enum logic [1:0] {
      BRTC_PW_OFF,
      BRTC_PW_CHECK,
      BRTC_PW_RUN
   } brtc_pwr_t;

endpackage

// ===== logic/brtc_bcd_cal.sv
/*
 * One-second BCD calendar advance: seconds through years, day of week,
 * month lengths, leap years and century rollover.
 * Assumes the input holds a legal 24-hour BCD time.
 */
`timescale 1ns/1ns
module brtc_bcd_cal (
   // Current time
   input  brtc_pkg::brtc_time_t now,
   // Time one second later
   output brtc_pkg::brtc_time_t nxt
);

   // ************************************************************
   // BCD helpers
   // ************************************************************
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] mon,
                                             input logic [7:0] yr);
      logic leap;
      // BCD year divisible by four: tens even and units in 0,4,8, or
      // tens odd and units in 2,6. Year 00 counts as leap (century 2000).
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      unique case (mon)
         8'h02:                      month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default:                    month_days = 8'h31;
      endcase
   endfunction

   // ************************************************************
   // Carry chain
   // ************************************************************
   always_comb begin
      nxt = now;
      if (now.sec != 8'h59) begin
         nxt.sec = bcd_inc(now.sec);
      end else begin
         nxt.sec = 8'h00;
         if (now.min != 8'h59) begin
            nxt.min = bcd_inc(now.min);
         end else begin
            nxt.min = 8'h00;
            if (now.hour != 8'h23) begin
               nxt.hour = bcd_inc(now.hour);
            end else begin
               nxt.hour = 8'h00;
               nxt.wday = (now.wday == 8'h07) ? 8'h01 : now.wday + 8'h01;
               if (now.date != month_days(now.month, now.year)) begin
                  nxt.date = bcd_inc(now.date);
               end else begin
                  nxt.date = 8'h01;
                  if (now.month != 8'h12) begin
                     nxt.month = bcd_inc(now.month);
                  end else begin
                     nxt.month = 8'h01;
                     nxt.year = (now.year == 8'h99) ? 8'h00
                                                    : bcd_inc(now.year);
                  end
               end
            end
         end
      end
   end

endmodule

// ===== logic/brtc_core.sv
/*
 * Real time clock core: running BCD counters, read hold, base time load,
 * oscillator fail detect, rate calibration, 512 Hz test output and alarm.
 * Assumes a synchronous host memory port (one-cycle read and write
 * strobes), an oscillator tick input synchronous to clk and a power-good
 * level standing for supply above the switch threshold.
 */
`timescale 1ns/1ns
`include "brtc_map.svh"

// Functional notes
// R01: Count seconds to years in BCD with weekday, leap and century.
// R02: Writing read-hold 1 freezes a snapshot; counting keeps running.
// R03: Clearing read-hold refreshes all visible registers together within 20 ms.
// R04: Host sets write-enable before writing 24-hour BCD time.
// R05: Clearing write-enable keeps base time and loads it into counters. The code loads only if a clock register was written since the last load.
// R06: Oscillator-disable bit 0 runs the oscillator, 1 stops it.
// R07: Oscillator may take up to ten seconds to start after enabling.
// R08: On power-up with oscillator enabled, no tick in 5 ms sets fail flag.
// R09: Fail flag setting restores clock to the last base time.
// R10: Fail flag is writable only while write-enable is high.
// R11: Host should clear fail flag on first clock write.
// R12: Calibration holds 5-bit magnitude and sign bit D5, 1 speeds up.
// R13: 64-minute cycle; one second per minute shortened 128 or lengthened 256; the 15-bit sum wraps, so a lengthened second lasts 256 ticks.
// R14: Magnitude N modifies the first 2N minutes of the cycle.
// R15: Frequency-test bit toggles interrupt output at 512 Hz, uncalibrated.
// R16: Frequency-test bit changes only inside a write-enable window.
// R17: Calibration resets to zero and survives main power loss.
// R18: Alarm registers match clock fields, set flag, maybe interrupt.
// R19: Reading the flags register clears the alarm flag.
// R20: Alarm register top bit 1 excludes that field from the match.
// R21: Host keeps the seconds alarm mask bit at 0.
// R22: Alarm writes are ignored unless write-enable is high.
// R23: Alarm drives the interrupt output only when alarm enable is 1.
// R24: Clock register reads return the snapshot while held, else live time.
module brtc_core #(
   parameter int OSC_FAIL_CYC = `BRTC_OSC_FAIL_CYC,
   parameter int REFRESH_CYC  = `BRTC_REFRESH_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Host memory port
   input  wire logic [16:0] addr,
   input  wire logic        rd_stb,
   input  wire logic        wr_stb,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata,
   // Oscillator and power
   input  wire logic        osc_tick,
   input  wire logic        power_good,
   output logic             osc_run,
   // Interrupt
   output logic             int_out
);

   // ************************************************************
   // State
   // ************************************************************
   brtc_pkg::brtc_time_t live_r, base_r, hold_r, live_inc;
   brtc_pkg::brtc_pwr_t  pwr_r;
   logic [7:0]  cal_r, intr_r;
   logic [7:0]  al_r [4];
   logic        rhold_r, wen_r, osc_fail_flag_r, caltest_r, af_r;
   logic        base_dirty_r, load_pend_r, refresh_pend_r;
   logic [14:0] tick_cnt_r;
   logic [5:0]  sec_in_min_r, min_in_cycle_r, test_cnt_r;
   logic        cal_done_r, test_r, match_prev_r;
   logic [31:0] wait_cnt_r, ref_cnt_r;

   logic        flags_rd, fail_set, sec_end, match_now;
   logic [14:0] sec_len;

   function automatic logic is_clock_addr(input logic [16:0] a);
      is_clock_addr = (a >= `BRTC_ADDR_SEC);
   endfunction

   function automatic logic [7:0] clock_field(input brtc_pkg::brtc_time_t t,
                                              input logic [16:0] a);
      unique case (a)
         `BRTC_ADDR_SEC:   clock_field = t.sec;
         `BRTC_ADDR_MIN:   clock_field = t.min;
         `BRTC_ADDR_HOUR:  clock_field = t.hour;
         `BRTC_ADDR_WDAY:  clock_field = t.wday;
         `BRTC_ADDR_DATE:  clock_field = t.date;
         `BRTC_ADDR_MONTH: clock_field = t.month;
         default:          clock_field = t.year;
      endcase
   endfunction

   brtc_bcd_cal u_cal (
      .now (live_r),
      .nxt (live_inc)
   );

   assign flags_rd = rd_stb && addr == `BRTC_ADDR_FLAGS;
   assign osc_run  = ~cal_r[`BRTC_CAL_OSCDIS];                 // [R06]

   // ************************************************************
   // Flags register
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rhold_r   <= 1'b0;
         wen_r     <= 1'b0;
         caltest_r <= 1'b0;
      end else if (wr_stb && addr == `BRTC_ADDR_FLAGS) begin
         rhold_r <= wdata[`BRTC_FL_READ];                      // [R02]
         wen_r   <= wdata[`BRTC_FL_WRITE];                     // [R04]
         if (wen_r) begin
            caltest_r <= wdata[`BRTC_FL_CAL];                  // [R16]
         end
      end
   end

   // Hardware set wins over a host clear in the same cycle.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_fail_flag_r <= 1'b0;
      end else if (fail_set) begin
         osc_fail_flag_r <= 1'b1;                                       // [R08]
      end else if (wr_stb && addr == `BRTC_ADDR_FLAGS && wen_r) begin
         osc_fail_flag_r <= wdata[`BRTC_FL_OSC_FAIL_FLAG];                       // [R10]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         af_r <= 1'b0;
      end else if (match_now && !match_prev_r) begin
         af_r <= 1'b1;                                         // [R18]
      end else if (flags_rd) begin
         af_r <= 1'b0;                                         // [R19]
      end
   end

   // ************************************************************
   // Calibration, interrupt and alarm registers
   // ************************************************************
   // The calibration value models nonvolatile storage: only sys_rst,
   // standing for factory state, returns it to zero.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cal_r  <= `BRTC_CAL_RESET;                            // [R17]
         intr_r <= 8'h00;
      end else if (wr_stb) begin
         if (addr == `BRTC_ADDR_CAL) begin
            cal_r <= wdata & 8'hbf;                            // [R12]
         end
         if (addr == `BRTC_ADDR_INTR) begin
            intr_r <= wdata;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_alarm
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               al_r[gi] <= 8'h00;
            end else if (wr_stb && wen_r &&
                         addr == `BRTC_ADDR_AL_SEC + 17'(gi)) begin
               al_r[gi] <= wdata;                              // [R22]
            end
         end
      end
   endgenerate

   // ************************************************************
   // Base time and load
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         base_r       <= '0;
         base_dirty_r <= 1'b0;
      end else if (wr_stb && wen_r && is_clock_addr(addr)) begin
         base_dirty_r <= 1'b1;
         unique case (addr)
            `BRTC_ADDR_SEC:   base_r.sec   <= wdata & 8'h7f;
            `BRTC_ADDR_MIN:   base_r.min   <= wdata & 8'h7f;
            `BRTC_ADDR_HOUR:  base_r.hour  <= wdata & 8'h3f;   // [R04]
            `BRTC_ADDR_WDAY:  base_r.wday  <= wdata & 8'h07;
            `BRTC_ADDR_DATE:  base_r.date  <= wdata & 8'h3f;
            `BRTC_ADDR_MONTH: base_r.month <= wdata & 8'h1f;
            default:          base_r.year  <= wdata;
         endcase
      end else if (load_pend_r) begin
         base_dirty_r <= 1'b0;
      end
   end

   // Load happens one cycle after write-enable falls, if a clock register was written.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_pend_r <= 1'b0;
      end else begin
         load_pend_r <= wr_stb && addr == `BRTC_ADDR_FLAGS && wen_r &&
                        !wdata[`BRTC_FL_WRITE] && base_dirty_r;
      end
   end

   // ************************************************************
   // Power-up oscillator check
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_r      <= brtc_pkg::BRTC_PW_OFF;
         wait_cnt_r <= '0;
      end else if (!power_good) begin
         pwr_r <= brtc_pkg::BRTC_PW_OFF;
      end else begin
         unique case (pwr_r)
            brtc_pkg::BRTC_PW_OFF: begin
               wait_cnt_r <= '0;
               pwr_r <= osc_run ? brtc_pkg::BRTC_PW_CHECK
                                : brtc_pkg::BRTC_PW_RUN;
            end
            brtc_pkg::BRTC_PW_CHECK: begin
               wait_cnt_r <= wait_cnt_r + 32'd1;
               if (osc_tick || fail_set) begin
                  pwr_r <= brtc_pkg::BRTC_PW_RUN;
               end
            end
            brtc_pkg::BRTC_PW_RUN: begin
               wait_cnt_r <= '0;
            end
         endcase
      end
   end

   assign fail_set = pwr_r == brtc_pkg::BRTC_PW_CHECK && !osc_tick &&
                     wait_cnt_r == 32'(OSC_FAIL_CYC - 1);      // [R08]

   // ************************************************************
   // Second divider with calibration
   // ************************************************************
   // Ticks arrive only while the oscillator runs, so a slow start simply
   // delays counting without extra logic.                     [R07]
   always_comb begin
      sec_len = `BRTC_TICKS_PER_SEC;
      if (!cal_done_r && min_in_cycle_r < {cal_r[4:0], 1'b0}) begin // [R14]
         sec_len = cal_r[`BRTC_CAL_SIGN]
                   ? `BRTC_TICKS_PER_SEC - 15'(`BRTC_CAL_SHORT)  // [R13]
                   : `BRTC_TICKS_PER_SEC + 15'(`BRTC_CAL_LONG);
      end
   end

   assign sec_end = osc_tick && osc_run && tick_cnt_r >= sec_len;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_r     <= '0;
         sec_in_min_r   <= '0;
         min_in_cycle_r <= '0;
         cal_done_r     <= 1'b0;
      end else if (sec_end) begin
         tick_cnt_r <= '0;
         if (sec_len != `BRTC_TICKS_PER_SEC) begin
            cal_done_r <= 1'b1;                                // [R13]
         end
         if (sec_in_min_r == 6'd59) begin
            sec_in_min_r   <= '0;
            cal_done_r     <= 1'b0;
            min_in_cycle_r <= min_in_cycle_r + 6'd1;           // 64-min wrap
         end else begin
            sec_in_min_r <= sec_in_min_r + 6'd1;
         end
      end else if (osc_tick && osc_run) begin
         tick_cnt_r <= tick_cnt_r + 15'd1;
      end
   end

   // ************************************************************
   // Running time
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         live_r <= '0;
      end else if (fail_set || load_pend_r) begin
         live_r <= base_r;                                     // [R05] [R09]
      end else if (sec_end) begin
         live_r <= live_inc;                                   // [R01]
      end
   end

   // Visible copy freezes on hold and refreshes at once after release.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_r         <= '0;
         refresh_pend_r <= 1'b0;
         ref_cnt_r      <= '0;
      end else if (!rhold_r) begin
         if (refresh_pend_r && ref_cnt_r < 32'(REFRESH_CYC - 1)) begin
            ref_cnt_r <= ref_cnt_r + 32'd1;
         end
         hold_r         <= live_r;                             // [R03]
         refresh_pend_r <= 1'b0;
      end else if (wr_stb && addr == `BRTC_ADDR_FLAGS &&
                   wdata[`BRTC_FL_READ] && !rhold_r) begin
         hold_r <= live_r;
      end else begin
         refresh_pend_r <= 1'b1;
         ref_cnt_r      <= '0;
      end
   end

   // ************************************************************
   // Alarm compare
   // ************************************************************
   logic [7:0] al_cmp [4];
   assign al_cmp[0] = live_r.sec;
   assign al_cmp[1] = live_r.min;
   assign al_cmp[2] = live_r.hour;
   assign al_cmp[3] = live_r.date;

   always_comb begin
      match_now = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (!al_r[i][7] && al_r[i][6:0] != al_cmp[i][6:0]) begin // [R20]
            match_now = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         match_prev_r <= 1'b1;
      end else begin
         match_prev_r <= match_now;
      end
   end

   // ************************************************************
   // Frequency test and interrupt output
   // ************************************************************
   // Raw oscillator ticks are divided here, ahead of the calibrated
   // divider, so calibration never shifts the test tone.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         test_cnt_r <= '0;
         test_r     <= 1'b0;
      end else if (osc_tick) begin
         if (test_cnt_r == `BRTC_TEST_HALF) begin
            test_cnt_r <= '0;
            test_r     <= ~test_r;                             // [R15]
         end else begin
            test_cnt_r <= test_cnt_r + 6'd1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_out <= 1'b0;
      end else if (caltest_r) begin
         int_out <= test_r;                                    // [R15]
      end else begin
         int_out <= af_r && intr_r[`BRTC_INT_AIE];             // [R23]
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         if (is_clock_addr(addr)) begin
            rdata <= clock_field(hold_r, addr);                // [R24]
         end else if (addr == `BRTC_ADDR_FLAGS) begin
            rdata <= 8'h00;
            rdata[`BRTC_FL_READ]  <= rhold_r;
            rdata[`BRTC_FL_WRITE] <= wen_r;
            rdata[`BRTC_FL_OSC_FAIL_FLAG]  <= osc_fail_flag_r;
            rdata[`BRTC_FL_CAL]   <= caltest_r;
            rdata[`BRTC_FL_AF]    <= af_r;
         end else if (addr == `BRTC_ADDR_CAL) begin
            rdata <= cal_r;
         end else if (addr == `BRTC_ADDR_INTR) begin
            rdata <= intr_r;
         end else if (addr >= `BRTC_ADDR_AL_SEC &&
                      addr <= `BRTC_ADDR_AL_DATE) begin
            rdata <= al_r[2'(addr - `BRTC_ADDR_AL_SEC)];
         end else begin
            rdata <= 8'h00;
         end
      end
   end

endmodule

// ===== sim/brtc_core_monitor.sv
/*
 * Port checker for the real time clock core.
 * Assumes a bind to brtc_core and an idle cycle between host accesses.
 */
`timescale 1ns/1ns
`include "brtc_map.svh"
module brtc_core_monitor #(
   parameter int OSC_FAIL_CYC = 20,
   parameter int REFRESH_CYC  = 10
) (
   // Clock, reset and host port
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [16:0] addr,
   input wire logic        rd_stb,
   input wire logic        wr_stb,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   // Oscillator, power and interrupt
   input wire logic        osc_tick,
   input wire logic        power_good,
   input wire logic        osc_run,
   input wire logic        int_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic       we_r, ft_r, aie_r, hold_r, armed_r;
   logic [6:0] ticks_r;
   // Mirrors of flag bits and of the interrupt register's alarm enable bit; the test bit follows only inside a write window.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {we_r, ft_r, hold_r, aie_r} <= 4'h0;
      end else if (wr_stb && addr == `BRTC_ADDR_FLAGS) begin
         we_r   <= wdata[`BRTC_FL_WRITE];
         hold_r <= wdata[`BRTC_FL_READ];
         ft_r   <= we_r ? wdata[`BRTC_FL_CAL] : ft_r;
      end else if (wr_stb && addr == `BRTC_ADDR_INTR) begin
         aie_r <= wdata[`BRTC_INT_AIE];
      end
   end
   // Ticks between test output edges; the first edge only arms the count.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ticks_r <= 7'h00;
         armed_r <= 1'b0;
      end else if (!ft_r || $changed(int_out)) begin
         ticks_r <= {6'h00, osc_tick && ft_r};
         armed_r <= ft_r;
      end else begin
         ticks_r <= ticks_r + {6'h00, osc_tick};
      end
   end
   sequence s_rd(logic [16:0] a);
      rd_stb && addr == a;
   endsequence
   sequence s_wr_cal;
      wr_stb && addr == `BRTC_ADDR_CAL;
   endsequence
   property p_rst;
      $fell(sys_rst) |-> rdata == 8'h00 && osc_run;
   endproperty
   property p_cal_zero;
      s_rd(`BRTC_ADDR_CAL) |=> rdata[6] == 1'b0;
   endproperty
   property p_cal_rb;
      s_wr_cal ##2 s_rd(`BRTC_ADDR_CAL) |=> rdata == ($past(wdata, 3) & 8'hbf);
   endproperty
   property p_osc;
      s_wr_cal |=> osc_run == !$past(wdata[`BRTC_CAL_OSCDIS]);
   endproperty
   property p_quiet;
      (!aie_r && !ft_r)[*3] |-> !int_out;
   endproperty
   property p_test_half;
      ft_r && armed_r && $changed(int_out) |-> ticks_r == 7'd32;
   endproperty
   property p_hold;
      hold_r ##0 s_rd(`BRTC_ADDR_SEC) ##2 s_rd(`BRTC_ADDR_SEC)
         |=> rdata == $past(rdata, 2);
   endproperty
   property p_af_clr;
      s_rd(`BRTC_ADDR_FLAGS) ##2 s_rd(`BRTC_ADDR_FLAGS) |=> !rdata[6];
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset state wrong");
   a_cal_zero: assert property (p_cal_zero)
      else $error("calibration bit 6 not zero");
   a_cal_rb: assert property (p_cal_rb)
      else $error("calibration readback wrong");
   a_osc: assert property (p_osc)
      else $error("osc_run does not follow disable bit");
   a_quiet: assert property (p_quiet)
      else $error("int_out high with alarm enable off");
   a_test_half: assert property (p_test_half)
      else $error("test half period not 32 ticks");
   a_hold: assert property (p_hold)
      else $error("held seconds changed");
   a_af_clr: assert property (p_af_clr)
      else $error("alarm flag survived a flags read");
endmodule

// ===== sim/brtc_host_model.sv
/*
 * Host processor model for the core's memory port.
 * Assumes byte accesses and an idle cycle between them.
 */
`timescale 1ns/1ns
module brtc_host_model (
   // Clock and read data
   input  wire logic        clk,
   input  wire logic [7:0]  rdata,
   // Request
   output logic      [16:0] addr,
   output logic             rd_stb,
   output logic             wr_stb,
   output logic      [7:0]  wdata
);
   initial {addr, rd_stb, wr_stb, wdata} = '0;
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      @(negedge clk);
      addr   = a;
      wdata  = d;
      wr_stb = 1'b1;
      @(negedge clk);
      wr_stb = 1'b0;
      // A released data bus must not keep showing the last byte.
      wdata  = ~d;
   endtask
   task automatic rd(input logic [16:0] a, output logic [7:0] d);
      @(negedge clk);
      addr   = a;
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      d      = rdata;
   endtask
endmodule

// ===== sim/brtc_core_tb.sv
/*
 * Self-checking bench for the real time clock core.
 * Assumes the host model and checker are compiled before it.
 */
`timescale 1ns/1ns
`include "brtc_map.svh"
module brtc_core_tb;
   localparam logic [16:0] FL = `BRTC_ADDR_FLAGS;
   localparam logic [16:0] SEC = `BRTC_ADDR_SEC;
   logic        clk, sys_rst, osc_tick, tick_en, power_good, lvl;
   logic        rd_stb, wr_stb, osc_run, int_out;
   logic [16:0] addr;
   logic [7:0]  wdata, rdata, v;
   logic [31:0] lfsr;
   int          failures, tests_run, cyc, n;
   byte         exp_q[$];
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(negedge clk) osc_tick <= tick_en && !osc_tick;
   brtc_host_model hst (.clk(clk), .rdata(rdata), .addr(addr),
      .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata));
   brtc_core #(.OSC_FAIL_CYC(20), .REFRESH_CYC(10)) dut (.clk(clk),
      .sys_rst(sys_rst), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
      .wdata(wdata), .rdata(rdata), .osc_tick(osc_tick),
      .power_good(power_good), .osc_run(osc_run), .int_out(int_out));
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim();
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rchk(input logic [16:0] a, input logic [7:0] m, e);
      hst.rd(a, v);
      check("rdata", v & m, e);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      {sys_rst, tick_en, power_good, osc_tick} = 4'b1010;
      {failures, tests_run, cyc} = '0;
      lfsr = 32'h04ab;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      rchk(`BRTC_ADDR_CAL, 8'hff, 8'h00);
      for (n = 0; n < 4; n++) begin
         lfsr = step(lfsr);
         hst.wr(`BRTC_ADDR_CAL, lfsr[7:0]);
         check("osc_run", {7'h0, osc_run}, {7'h0, !lfsr[7]});
         rchk(`BRTC_ADDR_CAL, 8'hff, lfsr[7:0] & 8'hbf);
      end
      hst.wr(`BRTC_ADDR_CAL, 8'h00);
      tick_en = 1'b1;
      hst.wr(FL, 8'h02);
      hst.wr(FL, 8'h02);
      exp_q = {8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
      for (n = 0; n < 7; n++)
         hst.wr(17'(SEC + n), exp_q[n]);
      hst.wr(`BRTC_ADDR_AL_SEC, 8'h00);
      for (n = 1; n < 4; n++)
         hst.wr(17'(`BRTC_ADDR_AL_SEC + n), 8'h85);
      hst.wr(`BRTC_ADDR_INTR, 8'h40);
      hst.wr(FL, 8'h00);
      hst.wr(`BRTC_ADDR_AL_SEC, 8'h30);
      rchk(`BRTC_ADDR_AL_SEC, 8'hff, 8'h00);
      hst.wr(FL, 8'h01);
      repeat (65600) @(negedge clk);
      for (n = 0; n < 2; n++)
         rchk(SEC, 8'hff, 8'h59);
      check("int_out", {7'h0, int_out}, 8'h01);
      hst.wr(FL, 8'h00);
      exp_q = {8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
      for (n = 0; n < 7; n++)
         rchk(17'(SEC + n), 8'hff, exp_q[n]);
      rchk(FL, 8'h40, 8'h40);
      rchk(FL, 8'h40, 8'h00);
      check("int_out", {7'h0, int_out}, 8'h00);
      tick_en = 1'b0;
      power_good = 1'b0;
      repeat (4) @(negedge clk);
      power_good = 1'b1;
      repeat (40) @(negedge clk);
      rchk(FL, 8'h04, 8'h04);
      rchk(SEC, 8'hff, 8'h59);
      hst.wr(FL, 8'h00);
      rchk(FL, 8'h04, 8'h04);
      hst.wr(FL, 8'h02);
      hst.wr(FL, 8'h02);
      hst.wr(FL, 8'h00);
      rchk(FL, 8'h04, 8'h00);
      tick_en = 1'b1;
      hst.wr(`BRTC_ADDR_CAL, 8'h25);
      hst.wr(FL, 8'h02);
      hst.wr(FL, 8'h0a);
      hst.wr(FL, 8'h08);
      hst.wr(FL, 8'h00);
      lvl = int_out;
      n = 0;
      repeat (640) begin
         @(negedge clk);
         n += int'(int_out != lvl);
         lvl = int_out;
      end
      check("toggles", 8'(n >= 9 && n <= 11), 8'h01);
      end_sim();
   end
endmodule
bind brtc_core brtc_core_monitor #(.OSC_FAIL_CYC(OSC_FAIL_CYC),
   .REFRESH_CYC(REFRESH_CYC)) u_mon (.clk(clk), .sys_rst(sys_rst),
   .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
   .rdata(rdata), .osc_tick(osc_tick), .power_good(power_good),
   .osc_run(osc_run), .int_out(int_out));
